// ### bench/lpc_panel_model.sv
// LCD panel model: counts pixel clocks, times the burst and latches data
`timescale 1ns/1ps
`default_nettype none
module lpc_panel_model (
	input wire logic panel_pixel_clock,
	input wire logic [7:0] panel_data,
	input wire logic ac_bias_output,
	input wire logic edge_sel,
	input wire logic en_lvl,
	input wire logic clr,
	output int count,
	output logic [7:0] last_data,
	output time first_t,
	output time last_t
);
	// Dropped slots carry no rising edge, so they never count
	always @(posedge panel_pixel_clock or posedge clr)
		if (clr)
			count <= 0;
		else
		begin
			if (count == 0)
				first_t <= $time;
			last_t <= $time;
			count <= count + 1;
		end
	// Latch on the edge opposite the drive edge, only while enabled
	always @(panel_pixel_clock)
		if (panel_pixel_clock == edge_sel && ac_bias_output == en_lvl)
			last_data <= panel_data;
endmodule // lpc_panel_model
`default_nettype wire

// ### bench/lpc_props.sv
// Checker for the pixel clock block, watching only its top-level ports
`timescale 1ns/1ps
`default_nettype none
module lpc_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic tft_mode,
	input wire logic vga_vsync,
	input wire logic frame_start,
	input wire logic pixel_taken,
	input wire logic panel_pixel_clock,
	input wire logic ac_bias_output,
	input wire logic line_pulse_output,
	input wire logic frame_sync_pulse
);
	logic [27:0] cfg, cfg_d;
	logic [5:0] hi;
	logic [10:0] n;
	wire logic lp_act = line_pulse_output ^ cfg_d[12];
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////
	// Outputs are registered, so polarity checks use the copy that lags one cycle
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			cfg <= '0;
			cfg_d <= '0;
		end
		else
		begin
			if (psel && penable && pwrite && pready && paddr == 12'h028)
				cfg <= pwdata[27:0];
			cfg_d <= cfg;
		end
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			hi <= '0;
			n <= '0;
		end
		else
		begin
			hi <= panel_pixel_clock ? hi + 6'h01 : 6'h00;
			n <= lp_act ? 11'h000 : n + 11'(pixel_taken);
		end
	////////////////////////////////////////
	a_ready_now: assert property (psel && penable |-> pready) else $error("wait state seen");
	a_err_unmapped: assert property (psel && penable && paddr != 12'h028 && paddr != 12'h02C |-> pslverr)
		else $error("no error on unmapped access");
	a_high_phase: assert property ($fell(panel_pixel_clock) && !cfg_d[26] |->
		hi == (6'(cfg_d[4:0]) + 6'h02) >> 1) else $error("pixel clock high phase wrong");
	a_oe_active: assert property (pixel_taken && tft_mode |-> ac_bias_output != cfg_d[14])
		else $error("data loaded while enable inactive");
	a_passive_ac: assert property (!tft_mode && $past(!tft_mode) |-> !ac_bias_output)
		else $error("enable driven in passive mode");
	a_edge_rise: assert property (pixel_taken && !cfg_d[13] && !cfg_d[26] |-> $rose(panel_pixel_clock))
		else $error("data not on rising edge");
	a_edge_fall: assert property (pixel_taken && cfg_d[13] && !cfg_d[26] |-> $fell(panel_pixel_clock))
		else $error("data not on falling edge");
	a_lp_inactive: assert property (pixel_taken |-> line_pulse_output == cfg_d[12])
		else $error("line pulse level wrong in burst");
	a_line_count: assert property ($rose(lp_act) |-> n == 11'(cfg_d[25:16]) + 11'h001)
		else $error("pixel clocks per line wrong");
	a_frame_sync: assert property (($rose(vga_vsync) && cfg_d[15]) || (frame_start && !cfg_d[15])
		|-> ##[1:3] frame_sync_pulse) else $error("frame sync missing");
	c_tft_load: cover property (pixel_taken && tft_mode);
	c_line_end: cover property ($rose(lp_act));
	c_frame: cover property (frame_sync_pulse);
endmodule // lpc_props
`default_nettype wire

// ### bench/lpc_top_test.sv
// Testbench for the pixel clock block: register access, line bursts, polarities, genlock
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module lpc_top_test;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tft_mode = 0, line_start = 0;
	logic frame_start = 0, vga_hsync = 0, vga_vsync = 0, clr = 0, edge_sel = 0, en_lvl = 0, e;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic [7:0] pixel_data_in = 0, panel_data, last_data;
	logic pready, pslverr, pixel_taken, panel_pixel_clock, ac_bias_output, line_pulse_output, frame_sync_pulse;
	int failures = 0, checks = 0, cyc = 0, count;
	time first_t, last_t;
	always #25 pclk = ~pclk;
	lpc_top DUT (.*);
	lpc_panel_model PANEL (.*);
	always @(posedge pclk)
		if (pixel_taken)
			pixel_data_in <= pixel_data_in + 8'h01;
	////////////////////////////////////////
	task give_verdict;
		if (failures == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			failures++;
			give_verdict();
		end
	end
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic run_line(input logic [31:0] c, input logic t, input int n, input int span);
		logic [7:0] s;
		apb(1'b1, 12'h028, c);
		tft_mode <= t;
		edge_sel <= c[13];
		en_lvl <= t & ~c[14];
		clr <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
		s = pixel_data_in;
		if (c[15])
			vga_hsync <= 1'b1;
		else
			line_start <= 1'b1;
		@(posedge pclk);
		line_start <= 1'b0;
		vga_hsync <= 1'b0;
		wait (line_pulse_output === ~c[12]);
		wait (line_pulse_output === c[12]);
		@(posedge pclk);
		`CHK(count, n)
		`CHK(int'((last_t - first_t) / 50), span)
		`CHK(ac_bias_output, t & c[14])
		if (!c[26])
			`CHK(last_data, 8'(s + n - 1 - c[13]))
	endtask
	////////////////////////////////////////
	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 12'h028, 32'h0000_0000);
		`CHK(r, 32'h0000_0000)
		apb(1'b1, 12'h028, 32'hFFFF_FFFF);
		apb(1'b0, 12'h028, 32'h0000_0000);
		`CHK(r, 32'h0FFF_FFFF)
		apb(1'b0, 12'h100, 32'h0000_0000);
		`CHK({e, r}, 33'h1_0000_0000)
		run_line(32'h0003_0000, 1'b0, 4, 6);
		apb(1'b0, 12'h02C, 32'h0000_0000);
		`CHK(r, 32'h0004_0000)
		run_line(32'h0805_1003, 1'b0, 6, 30);
		run_line(32'h0807_0000, 1'b0, 8, 18);
		run_line(32'h0002_6001, 1'b1, 3, 6);
		run_line(32'h0403_0000, 1'b1, 4, 3);
		apb(1'b1, 12'h028, 32'h0001_8000);
		clr <= 1'b1;
		line_start <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
		line_start <= 1'b0;
		repeat (20) @(posedge pclk);
		`CHK(count, 0)
		run_line(32'h0001_8000, 1'b0, 2, 2);
		vga_vsync <= 1'b1;
		@(posedge pclk);
		@(negedge pclk);
		`CHK(frame_sync_pulse, 1'b1)
		repeat (3) @(posedge pclk);
		vga_vsync <= 1'b0;
		apb(1'b1, 12'h028, 32'h0000_0000);
		frame_start <= 1'b1;
		@(posedge pclk);
		frame_start <= 1'b0;
		@(negedge pclk);
		`CHK(frame_sync_pulse, 1'b1)
		repeat (4) @(posedge pclk);
		give_verdict();
	end
endmodule // lpc_top_test
bind lpc_top lpc_props PROPS (.*);
`default_nettype wire

// ### pkg/lpc_map.svh
// Register map, field positions, reset values and the operating summary of the pixel clock block
// Summary of operation
// - Fourth-pulse-drop set: every fourth pixel clock period stays low, three of four pulse.
// - Divisor zero gives pixel clock at half source rate.
// - Bypass set: undivided source clock goes out as pixel clock.
// - Each line emits clocks-per-line field plus one pixel clocks; field ten bits.
// - Genlock select locks line and frame sync to the VGA timing generator.
// - In TFT mode the AC-bias output is an output enable during pixel bursts.
// - In TFT mode data changes on the selected edge only while enable is active.
// - Without bypass, pixel edge select 0 drives data on rising edge, 1 on falling edge; bypass uses the rising edge only.
// - Line-pulse invert 0 makes the line pulse active high, inactive low.
// - Line-pulse invert 1 makes the line pulse active low, inactive high.
// - Without bypass, pixel clock period is pixel divisor plus two source clocks.
`ifndef LPC_MAP_SVH
`define LPC_MAP_SVH
`define LPC_OFS_TIMING2 12'h028
`define LPC_OFS_STATUS 12'h02C
`define LPC_TIMING2_RESET 32'h0000_0000
`define LPC_TIMING2_WMASK 32'h0FFF_FFFF
`define LPC_BIT_DROP 27
`define LPC_BIT_BYPASS 26
`define LPC_CPL_MSB 25
`define LPC_CPL_LSB 16
`define LPC_BIT_GENLOCK 15
`define LPC_BIT_OE_INV 14
`define LPC_BIT_EDGE 13
`define LPC_BIT_LP_INV 12
`define LPC_PCD_MSB 4
`define LPC_PCD_LSB 0
`define LPC_STAT_BIT_BUSY 0
`define LPC_STAT_BIT_LP 1
`define LPC_STAT_CNT_MSB 25
`define LPC_STAT_CNT_LSB 16
`define LPC_DROP_SLOT 2'h3
`endif

// ### pkg/lpc_pkg.sv
// Types shared by the pixel clock and polarity block
package lpc_pkg;
	typedef enum logic [1:0] {
		lpc_idle,
		lpc_burst,
		lpc_line_pulse
	} lpc_state_t;
endpackage

// ### verilog/lpc_top.sv
// Pixel clock shaping, line burst counting, genlock and panel output polarities with APB registers
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "lpc_map.svh"
module lpc_top #(
	parameter int DATA_W = 8,
	parameter int CPL_W = 10,
	parameter int PCD_W = 5
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic tft_mode,
	input wire logic line_start,
	input wire logic frame_start,
	input wire logic vga_hsync,
	input wire logic vga_vsync,
	input wire logic [DATA_W-1:0] pixel_data_in,
	output logic pixel_taken,
	output logic panel_pixel_clock,
	output logic [DATA_W-1:0] panel_data,
	output logic ac_bias_output,
	output logic line_pulse_output,
	output logic frame_sync_pulse
);

////////////////////////////////////////////////////////////////////////////////
// Register file

logic [31:0] lcd_timing_control_2;
lpc_pkg::lpc_state_t state;
logic [CPL_W-1:0] clk_count;
logic setup_rd;
logic hit_timing;
logic hit_status;
logic [31:0] stat_word;

assign hit_timing = (paddr == `LPC_OFS_TIMING2);
assign hit_status = (paddr == `LPC_OFS_STATUS);
// Zero wait states: every access completes in its first access cycle
assign pready = 1'b1;
assign pslverr = psel & penable & ~(hit_timing | hit_status);
assign setup_rd = psel & ~penable & ~pwrite;

always_comb
begin
	stat_word = 32'h0000_0000;
	stat_word[`LPC_STAT_BIT_BUSY] = (state == lpc_pkg::lpc_burst);
	stat_word[`LPC_STAT_BIT_LP] = (state == lpc_pkg::lpc_line_pulse);
	stat_word[`LPC_STAT_CNT_MSB:`LPC_STAT_CNT_LSB] = clk_count;
end

always_ff @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		lcd_timing_control_2 <= `LPC_TIMING2_RESET;
	else if (psel && penable && pwrite && hit_timing)
		lcd_timing_control_2 <= pwdata & `LPC_TIMING2_WMASK;
end

// Read data is captured in the setup cycle so it leaves a flop
always_ff @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		prdata <= 32'h0000_0000;
	else if (setup_rd)
	begin
		if (hit_timing)
			prdata <= lcd_timing_control_2;
		else if (hit_status)
			prdata <= stat_word;
		else
			prdata <= 32'h0000_0000;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Field decode

logic drop_en;
logic bypass;
logic [CPL_W-1:0] clocks_per_line_field;
logic genlock;
logic oe_inv;
logic edge_sel;
logic lp_inv;
logic [PCD_W-1:0] pixel_divisor;

assign drop_en = lcd_timing_control_2[`LPC_BIT_DROP];
assign bypass = lcd_timing_control_2[`LPC_BIT_BYPASS];
assign clocks_per_line_field = lcd_timing_control_2[`LPC_CPL_MSB:`LPC_CPL_LSB];
assign genlock = lcd_timing_control_2[`LPC_BIT_GENLOCK];
assign oe_inv = lcd_timing_control_2[`LPC_BIT_OE_INV];
assign edge_sel = lcd_timing_control_2[`LPC_BIT_EDGE];
assign lp_inv = lcd_timing_control_2[`LPC_BIT_LP_INV];
assign pixel_divisor = lcd_timing_control_2[`LPC_PCD_MSB:`LPC_PCD_LSB];

////////////////////////////////////////////////////////////////////////////////
// Line and frame start, local or locked to the VGA generator

logic hs_prev;
logic vs_prev;
logic line_go;
logic frame_go;

always_ff @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		hs_prev <= 1'b0;
		vs_prev <= 1'b0;
	end
	else
	begin
		hs_prev <= vga_hsync;
		vs_prev <= vga_vsync;
	end
end

assign line_go = genlock ? (vga_hsync & ~hs_prev) : line_start;
assign frame_go = genlock ? (vga_vsync & ~vs_prev) : frame_start;

always_ff @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		frame_sync_pulse <= 1'b0;
	else
		frame_sync_pulse <= frame_go;
end

////////////////////////////////////////////////////////////////////////////////
// Divider phase and drop slot

logic [PCD_W:0] phase;
logic [PCD_W:0] div_max;
logic [PCD_W:0] half;
logic [1:0] slot;
logic period_start;
logic period_end;
logic emit;

// Period of divisor plus two source clocks, or one clock in bypass
assign div_max = bypass ? '0 : ({1'b0, pixel_divisor} + (PCD_W+1)'(1));
// High phase is the first half; divisor zero gives one high, one low
assign half = (div_max + (PCD_W+1)'(1)) >> 1;
assign period_start = (phase == '0);
assign period_end = (phase == div_max);
assign emit = (state == lpc_pkg::lpc_burst) && !(drop_en && slot == `LPC_DROP_SLOT);

always_ff @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		phase <= '0;
	else if (period_end || state == lpc_pkg::lpc_idle)
		phase <= '0;
	else
		phase <= phase + (PCD_W+1)'(1);
end

// Slot index restarts each line so the drop pattern is line aligned
always_ff @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		slot <= 2'h0;
	else if (state != lpc_pkg::lpc_burst)
		slot <= 2'h0;
	else if (period_end)
		slot <= slot + 2'h1;
end

////////////////////////////////////////////////////////////////////////////////
// Line sequencer

logic bypass_gate;
// Sampled on the low half so the gated source clock has no runt pulse at burst start or end
always_ff @(negedge pclk or negedge presetn)
begin
	if (!presetn)
		bypass_gate <= 1'b0;
	else
		bypass_gate <= emit;
end
always_ff @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		clk_count <= '0;
	else if (state == lpc_pkg::lpc_idle && line_go)
		clk_count <= '0;
	else if (state == lpc_pkg::lpc_burst && period_start && emit)
		clk_count <= clk_count + CPL_W'(1);
end
logic cpl_reached;
logic [CPL_W:0] count_ext;
assign count_ext = {1'b0, clk_count} + ((state == lpc_pkg::lpc_burst && period_start && emit) ? (CPL_W+1)'(1) : '0);
assign cpl_reached = (count_ext == ({1'b0, clocks_per_line_field} + (CPL_W+1)'(1)));
logic burst_ends;
logic line_done;
always_ff @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		line_done <= 1'b0;
	else if (state != lpc_pkg::lpc_burst)
		line_done <= 1'b0;
	else if (cpl_reached)
		line_done <= 1'b1;
end
assign burst_ends = period_end && (line_done || cpl_reached);

always_ff @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		state <= lpc_pkg::lpc_idle;
	else
	begin
		case (state)
			lpc_pkg::lpc_idle:
				if (line_go)
					state <= lpc_pkg::lpc_burst;
			lpc_pkg::lpc_burst:
				if (burst_ends)
					state <= lpc_pkg::lpc_line_pulse;
			lpc_pkg::lpc_line_pulse:
				if (period_end)
					state <= lpc_pkg::lpc_idle;
			default:
				state <= lpc_pkg::lpc_idle;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// Panel outputs

logic cp_div;
logic next_cp_div;
logic rise_evt;
logic fall_evt;

// High for phases one to half of its own period, so a pulse never borrows a neighbouring slot
assign next_cp_div = emit && !bypass && (phase < half);
assign rise_evt = bypass ? emit : (next_cp_div && !cp_div);
assign fall_evt = bypass ? emit : (cp_div && !next_cp_div);
always_ff @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		cp_div <= 1'b0;
	else
		cp_div <= next_cp_div;
end

// Bypass gates the source clock itself, so it is kept for TFT; data then moves on its rising edge only
assign panel_pixel_clock = bypass ? (pclk & bypass_gate) : cp_div;

always_ff @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		panel_data <= '0;
		pixel_taken <= 1'b0;
	end
	else
	begin
		pixel_taken <= 1'b0;
		// Data moves only inside a burst, where the enable is active
		if ((edge_sel ? fall_evt : rise_evt) && (state == lpc_pkg::lpc_burst))
		begin
			panel_data <= pixel_data_in;
			pixel_taken <= 1'b1;
		end
	end
end

always_ff @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		ac_bias_output <= 1'b0;
	else if (tft_mode)
		ac_bias_output <= (state == lpc_pkg::lpc_burst) ^ oe_inv;
	else
		ac_bias_output <= 1'b0;
end

always_ff @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		line_pulse_output <= 1'b0;
	else
		line_pulse_output <= (state == lpc_pkg::lpc_line_pulse) ^ lp_inv;
end

endmodule // lpc_top
`default_nettype wire
